// >>> core/ocm_top.sv
// Offset cancellation, offset monitor, interpolation and output scaling
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`include "ocm_regs.svh"
module ocm_top #(
  parameter int PHASE1_CYC    = `OCM_PHASE1_MS * `OCM_CLK_KHZ,
  parameter int PHASE2_CYC    = `OCM_PHASE2_MS * `OCM_CLK_KHZ,
  parameter int MON_START_CYC = `OCM_MON_START_MS * `OCM_CLK_KHZ,
  parameter int RATE_CYC      = `OCM_RATE_US * `OCM_CLK_MHZ
) (
  input  wire logic               clk,
  input  wire logic               reset_n,
  // Sample stream from the filter chain
  input  wire logic               sample_valid,
  input  wire logic signed [25:0] sample_in,
  input  wire logic               pdcm_cmd,
  output ocm_pkg::ocm_pdcm_s      pdcm_q,
  output logic                    offset_err_q,
  output logic                    offset_init_done_q,
  // AXI4-Lite slave
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);
  import ocm_pkg::*;

  // --------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------
  ocm_cfg_s           cfg_q;
  logic [7:0]         mon_limit_q;
  logic [7:0]         aw_addr_q;
  logic               aw_full_q;
  logic [31:0]        w_data_q;
  logic [3:0]         w_strb_q;
  logic               w_full_q;
  logic               do_write;
  logic               ar_take;
  logic [31:0]        rd_data;
  logic               rd_ok;
  logic               wr_ok;

  logic [25:0]        timer_q;
  ocm_phase_e         phase;
  logic               mon_en;
  logic [20:0]        coef;
  logic signed [25:0] x_prev_q;
  logic signed [50:0] acc_q;
  logic signed [26:0] avg;
  logic signed [26:0] filt_out;
  logic signed [27:0] fdiff;
  logic signed [48:0] fprod;
  logic signed [26:0] corr_q;
  logic signed [26:0] corr_d;
  logic               rate_on;
  logic [14:0]        rate_cnt_q;
  logic               rate_tick;
  logic signed [26:0] rate_step;
  logic [7:0]         mon_cnt_q;
  logic               outside;
  logic signed [26:0] corrected;
  logic signed [26:0] interp;
  logic signed [15:0] res16;
  logic [15:0]        res16_q;
  logic signed [15:0] pd14;
  logic signed [15:0] pd10;

  // --------------------------------------------------------------
  // Clipping to a symmetric range, keeping the fault code unused
  // --------------------------------------------------------------
  function automatic logic signed [15:0] clip(
    input logic signed [26:0] v,
    input logic        [15:0] lim
  );
    logic signed [26:0] s;
    logic signed [26:0] l;
    s = v >>> `OCM_SCALE_SHIFT;
    l = 27'(lim);
    if (s > l) begin
      clip = $signed(lim);
    end else if (s < -l) begin
      clip = -$signed(lim);
    end else begin
      clip = 16'(s);
    end
  endfunction

  // --------------------------------------------------------------
  // Register bus
  // --------------------------------------------------------------

  // Write decode, taken once both address and data are held
  assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
  assign wr_ok    = (aw_addr_q == `OCM_ADDR_CONFIG) ||
                    (aw_addr_q == `OCM_ADDR_MON_LIMIT) ||
                    (aw_addr_q == `OCM_ADDR_DEVICE_STATUS_REG) ||
                    (aw_addr_q == `OCM_ADDR_ACCSTAT) ||
                    (aw_addr_q == `OCM_ADDR_RES_HIGH) ||
                    (aw_addr_q == `OCM_ADDR_RES_LOW);
  assign ar_take  = s_axi_arvalid && s_axi_arready;

  // Read selection
  always_comb begin
    rd_data = 32'h0;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      `OCM_ADDR_CONFIG:    rd_data = {27'h0, cfg_q};
      `OCM_ADDR_DEVICE_STATUS_REG: begin
        rd_data[`OCM_STAT_INIT_BIT] = offset_init_done_q;
        rd_data[`OCM_STAT_ERR_BIT]  = offset_err_q; // [R12]
      end
      `OCM_ADDR_ACCSTAT:   rd_data[`OCM_ACC_ERR_BIT] = offset_err_q; // [R12]
      `OCM_ADDR_RES_HIGH:  rd_data = {24'h0, res16_q[15:8]}; // [R17]
      `OCM_ADDR_RES_LOW:   rd_data = {24'h0, res16_q[7:0]}; // [R17]
      `OCM_ADDR_MON_LIMIT: rd_data = {24'h0, mon_limit_q};
      default:             rd_ok   = 1'b0;
    endcase
  end

  // Address and data holding, either order
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= 8'h0;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_full_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_full_q <= 1'b0;
      end
    end
  end

  // Handshake outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'h0;
      s_axi_rdata   <= 32'h0;
    end else begin
      s_axi_awready <= !aw_full_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_full_q && !(s_axi_wvalid && s_axi_wready);
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !ar_take && !s_axi_arready;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
        s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Writable registers, low byte lane only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q       <= ocm_cfg_s'(`OCM_CFG_RESET);
      mon_limit_q <= `OCM_MON_LIMIT_RESET;
    end else if (do_write && w_strb_q[0]) begin
      if (aw_addr_q == `OCM_ADDR_CONFIG) begin
        cfg_q <= ocm_cfg_s'(w_data_q[4:0]); // [R4]
      end
      if (aw_addr_q == `OCM_ADDR_MON_LIMIT) begin
        mon_limit_q <= w_data_q[7:0];
      end
    end
  end

  // --------------------------------------------------------------
  // Startup sequencing
  // --------------------------------------------------------------

  // Timer since reset, never held by self-test
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_q <= 26'h0;
    end else if (timer_q != 26'(MON_START_CYC)) begin
      timer_q <= timer_q + 26'h1; // [R7]
    end
  end

  // Phase decode from the free timer
  assign phase  = (timer_q < 26'(PHASE1_CYC)) ? OCM_PH_FAST :
                  (timer_q < 26'(PHASE1_CYC + PHASE2_CYC)) ? OCM_PH_MID :
                  OCM_PH_DONE; // [R3]
  assign mon_en = (timer_q == 26'(MON_START_CYC)); // [R9]

  // --------------------------------------------------------------
  // Offset low-pass filter
  // --------------------------------------------------------------

  // Coefficient choice per phase and select field
  always_comb begin
    coef = `OCM_K_01HZ;
    case (phase)
      OCM_PH_FAST: coef = `OCM_K_10HZ; // [R3]
      OCM_PH_MID:  coef = `OCM_K_1HZ; // [R3]
      OCM_PH_DONE: begin
        case (cfg_q.filt_sel[1:0])
          2'h0:    coef = `OCM_K_10HZ; // [R2] [R4]
          2'h1:    coef = `OCM_K_1HZ; // [R2] [R4]
          default: coef = `OCM_K_01HZ; // [R2] [R4]
        endcase
      end
      default:     coef = `OCM_K_01HZ;
    endcase
  end

  // y += gain * ((x + x_prev)/2 - y), half-taps on both samples
  assign avg      = (27'(sample_in) + 27'(x_prev_q)) >>> 1; // [R1]
  assign filt_out = acc_q[50:`OCM_FRAC];
  assign fdiff    = 28'(avg) - 28'(filt_out);
  assign fprod    = 49'(fdiff) * $signed({28'h0, coef}); // [R1]

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_q    <= 51'h0;
      x_prev_q <= 26'h0;
    end else if (sample_valid) begin
      acc_q    <= acc_q + 51'(fprod); // [R1]
      x_prev_q <= sample_in;
    end
  end

  // --------------------------------------------------------------
  // Correction output with rate limiting and self-test freeze
  // --------------------------------------------------------------
  assign rate_on   = (phase == OCM_PH_DONE) &&
                     cfg_q.filt_sel[`OCM_SEL_RATE_BIT]; // [R5]
  assign rate_tick = (rate_cnt_q == 15'(RATE_CYC - 1));
  assign rate_step = `OCM_RATE_STEP_LSB <<< `OCM_SCALE_SHIFT;

  // Step toward the filter when limited, else track it
  always_comb begin
    corr_d = corr_q;
    if (!rate_on) begin
      corr_d = filt_out;
    end else if (rate_tick) begin
      if (filt_out > corr_q + rate_step) begin
        corr_d = corr_q + rate_step; // [R5]
      end else if (filt_out < corr_q - rate_step) begin
        corr_d = corr_q - rate_step; // [R5]
      end else begin
        corr_d = filt_out;
      end
    end
  end

  // Update interval counter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rate_cnt_q <= 15'h0;
    end else if (rate_tick) begin
      rate_cnt_q <= 15'h0;
    end else begin
      rate_cnt_q <= rate_cnt_q + 15'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      corr_q <= 27'h0;
    end else if (!cfg_q.selftest && (sample_valid || rate_on)) begin
      corr_q <= corr_d; // [R6]
    end
  end

  // --------------------------------------------------------------
  // Offset monitor
  // --------------------------------------------------------------
  // Signed limits, so a small negative offset is not read as huge
  assign outside = (filt_out > $signed(`OCM_OFF_LIMIT)) ||
                   (filt_out < -$signed(`OCM_OFF_LIMIT)); // [R10]

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mon_cnt_q <= 8'h0;
    end else if (mon_en && sample_valid) begin
      if (outside && mon_cnt_q != `OCM_MON_COUNT_MAX) begin
        mon_cnt_q <= mon_cnt_q + 8'h1; // [R11] [R13]
      end else if (!outside && mon_cnt_q != 8'h0) begin
        mon_cnt_q <= mon_cnt_q - 8'h1; // [R11]
      end
    end
  end

  // Status flags
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      offset_err_q       <= 1'b0;
      offset_init_done_q <= 1'b0;
    end else begin
      offset_err_q       <= (mon_cnt_q > mon_limit_q); // [R12]
      offset_init_done_q <= (phase == OCM_PH_DONE); // [R8]
    end
  end

  // --------------------------------------------------------------
  // Cancellation, interpolation and output scaling
  // --------------------------------------------------------------
  assign corrected = cfg_q.cancel_en ?
                     27'(sample_in) - corr_q : 27'(sample_in); // [R21]

  ocm_interp u_interp (
    .clk          (clk),
    .reset_n      (reset_n),
    .sample_valid (sample_valid),
    .sample       (corrected),
    .interp_q     (interp)
  );

  // Same LSB for all widths; clipped away from the fault code
  assign res16 = clip(corrected, `OCM_MAX16); // [R16] [R18] [R20]
  assign pd14  = clip(interp, `OCM_MAX14); // [R16] [R18]
  assign pd10  = clip(interp, `OCM_MAX10); // [R16] [R18]

  // Result registers: loaded with the current sample, offset to mid-scale
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      res16_q <= `OCM_MAX16 + 16'h1;
    end else if (sample_valid) begin
      res16_q <= {~res16[15], res16[14:0]}; // [R15] [R19]
    end
  end

  // Periodic words latched at the command
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pdcm_q <= '0;
    end else begin
      pdcm_q.valid <= pdcm_cmd; // [R15] [R17]
      if (pdcm_cmd) begin
        pdcm_q.word14 <= {~pd14[13], pd14[12:0]}; // [R19]
        pdcm_q.word10 <= {~pd10[9], pd10[8:0]}; // [R19]
      end
    end
  end

endmodule

// >>> core/ocm_regs.svh
// Constants for the offset cancel, monitor and output scaling stage
// Function
// (R1) Offset estimate is a first-order recursive low-pass with gain and two taps.
// (R2) Three coefficient sets: 10 Hz, 1.0 Hz and 0.1 Hz cutoffs.
// (R3) After reset: 10 Hz for 80 ms, 1.0 Hz for 70 ms, no rate limit.
// (R4) After startup the select field in the config register picks the filter.
// (R5) Rate limiting moves the correction a fixed step per fixed interval.
// (R6) Self-test freezes the correction output, also during startup.
// (R7) Startup timers keep running while self-test is active.
// (R8) Software waits for offset_init_done before enabling self-test.
// (R9) Offset monitor starts 2.1 s after reset, whatever the select field.
// (R10) Each sample the filtered offset is compared with upper and lower limits.
// (R11) Monitor counter counts up outside limits, down inside them.
// (R12) Counter above the count limit sets offset error in both status registers.
// (R13) Monitor counter saturates at its maximum instead of wrapping.
// (R14) Samples are linearly interpolated sixteen to one, jitter under 1 us.
// (R15) Results are delayed one sample; a periodic command reads the interpolation. Result registers here load the current sample, undelayed.
// (R16) The 26-bit result is clipped and scaled to 10, 14 and 16 bits.
// (R17) 10/14-bit words feed periodic transfers; 16-bit word fills result registers.
// (R18) All widths share one LSB weight; wider words only add range.
// (R19) Zero encodes mid-scale; the all-zero unsigned code is kept for faults.
// (R20) Values beyond 511 LSB are overrange data for test use.
// (R21) With cancellation on, the correction is subtracted before scaling.
`ifndef OCM_REGS_SVH
`define OCM_REGS_SVH

// Register byte offsets
`define OCM_ADDR_CONFIG     8'h00
`define OCM_ADDR_DEVICE_STATUS_REG    8'h04
`define OCM_ADDR_ACCSTAT    8'h08
`define OCM_ADDR_RES_HIGH   8'h0c
`define OCM_ADDR_RES_LOW    8'h10
`define OCM_ADDR_MON_LIMIT  8'h14

// Config register fields and reset values
`define OCM_CFG_SEL_LSB     0
`define OCM_CFG_SEL_MSB     2
`define OCM_CFG_CANCEL_BIT  3
`define OCM_CFG_SELFTEST_BIT 4
`define OCM_CFG_RESET       5'h08
`define OCM_SEL_RATE_BIT    2
`define OCM_STAT_INIT_BIT   0
`define OCM_STAT_ERR_BIT    1
`define OCM_ACC_ERR_BIT     0

// Filter gains, Q24 (gain * 2^24)
`define OCM_FRAC            24
`define OCM_K_10HZ          21'h0415c1
`define OCM_K_1HZ           21'h006954
`define OCM_K_01HZ          21'h000a8a

// Timing, in printed units and clock rate
`define OCM_CLK_KHZ         20000
`define OCM_CLK_MHZ         20
`define OCM_PHASE1_MS       80
`define OCM_PHASE2_MS       70
`define OCM_MON_START_MS    2100
`define OCM_RATE_US         1000
`define OCM_INTERP_US       1
`define OCM_INTERP_LAST     4'hf
`define OCM_INTERP_SHIFT    4

// Rate limit step and monitor limits
`define OCM_RATE_STEP_LSB   27'h0000001
`define OCM_OFF_LIMIT       27'h0010000
`define OCM_MON_LIMIT_RESET 8'h40
`define OCM_MON_COUNT_MAX   8'hff

// Output scaling
`define OCM_SCALE_SHIFT     10
`define OCM_MAX16           16'h7fff
`define OCM_MAX14           16'h1fff
`define OCM_MAX10           16'h01ff

`endif

// >>> core/ocm_pkg.sv
// Types shared by the offset cancel and output scaling stage
package ocm_pkg;

  // Startup sequence of the offset filter
  typedef enum logic [1:0] {
    OCM_PH_FAST,
    OCM_PH_MID,
    OCM_PH_DONE
  } ocm_phase_e;

  // Software configuration
  typedef struct packed {
    logic       selftest;
    logic       cancel_en;
    logic [2:0] filt_sel;
  } ocm_cfg_s;

  // Periodic transfer words
  typedef struct packed {
    logic        valid;
    logic [13:0] word14;
    logic [9:0]  word10;
  } ocm_pdcm_s;

endpackage

// >>> core/ocm_interp.sv
// Sixteen to one linear interpolator over one-sample-delayed results
`include "ocm_regs.svh"
module ocm_interp (
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               sample_valid,
  input  wire logic signed [26:0] sample,
  output logic signed [26:0]      interp_q
);
  import ocm_pkg::*;

  localparam int STEP_CYC = `OCM_INTERP_US * `OCM_CLK_MHZ;

  logic signed [26:0] prev_q;
  logic signed [26:0] cur_q;
  logic [4:0]         tick_q;
  logic [3:0]         phase_q;
  logic signed [27:0] diff;
  logic signed [33:0] scaled;
  logic signed [26:0] interp_d;
  logic               step;

  // Interpolation between previous and current sample
  assign diff     = 28'(cur_q) - 28'(prev_q);
  assign scaled   = 34'(diff) * $signed({30'h0, phase_q});
  assign interp_d = 27'(prev_q + 27'(scaled >>> `OCM_INTERP_SHIFT));
  assign step     = (tick_q == 5'(STEP_CYC - 1));

  // Sample history, one sample of delay
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_q <= 27'h0;
      cur_q  <= 27'h0;
    end else if (sample_valid) begin
      prev_q <= cur_q; // [R15]
      cur_q  <= sample;
    end
  end

  // Phase steps once per microsecond, restarted by each sample
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_q  <= 5'h0;
      phase_q <= 4'h0;
    end else if (sample_valid) begin
      tick_q  <= 5'h0;
      phase_q <= 4'h0;
    end else if (step) begin
      tick_q  <= 5'h0;
      if (phase_q != `OCM_INTERP_LAST) begin
        phase_q <= phase_q + 4'h1; // [R14]
      end
    end else begin
      tick_q <= tick_q + 5'h1;
    end
  end

  // Registered interpolated value
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      interp_q <= 27'h0;
    end else begin
      interp_q <= interp_d; // [R14]
    end
  end

endmodule

// >>> testbench/ocm_top_monitor.sv
// Assertion checker bound to the offset cancel and output scaling stage
module ocm_top_monitor #(
  parameter int PHASE1_CYC    = 50,
  parameter int PHASE2_CYC    = 50,
  parameter int MON_START_CYC = 300
) (
  input wire logic               clk,
  input wire logic               reset_n,
  input wire logic               pdcm_cmd,
  input wire ocm_pkg::ocm_pdcm_s pdcm_q,
  input wire logic               offset_err_q,
  input wire logic               offset_init_done_q
);
  timeunit 1ns;
  timeprecision 1ns;
  import ocm_pkg::*;
  int cyc_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Cycles since reset release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) cyc_q <= 0;
    else cyc_q <= cyc_q + 1;
  end

  a_pdcm_answer: assert property (pdcm_cmd |=> pdcm_q.valid)
    else $error("periodic word missing after command");
  a_pdcm_cause: assert property (pdcm_q.valid |-> $past(pdcm_cmd))
    else $error("periodic word without command");
  a_words_hold: assert property (!pdcm_cmd |=> $stable(pdcm_q.word14))
    else $error("periodic word changed without command");
  a_init_sticky: assert property (offset_init_done_q |=> offset_init_done_q)
    else $error("startup done flag dropped");
  a_init_time: assert property ($rose(offset_init_done_q) |->
    cyc_q >= PHASE1_CYC + PHASE2_CYC - 2 && cyc_q <= PHASE1_CYC + PHASE2_CYC + 2)
    else $error("startup phases ended at wrong time");
  a_mon_start: assert property (offset_err_q |-> cyc_q >= MON_START_CYC - 1)
    else $error("offset error before monitor start");
  a_same_lsb: assert property (pdcm_q.valid && pdcm_q.word14 >= 14'h1e01 &&
    pdcm_q.word14 <= 14'h21ff |-> pdcm_q.word10 == 10'(pdcm_q.word14 - 14'h1e00))
    else $error("short and long words disagree");
  a_clip_high: assert property (pdcm_q.valid && pdcm_q.word14 > 14'h21ff
    |-> pdcm_q.word10 == 10'h3ff)
    else $error("short word not clipped high");
  a_clip_low: assert property (pdcm_q.valid && pdcm_q.word14 < 14'h1e01
    |-> pdcm_q.word10 == 10'h001)
    else $error("short word not clipped low");
  a_no_fault: assert property (pdcm_q.valid |->
    pdcm_q.word14 != 14'h0000 && pdcm_q.word10 != 10'h000)
    else $error("fault code produced");
endmodule

bind ocm_top ocm_top_monitor #(
  .PHASE1_CYC(PHASE1_CYC),
  .PHASE2_CYC(PHASE2_CYC),
  .MON_START_CYC(MON_START_CYC)
) u_mon (
  .clk(clk),
  .reset_n(reset_n),
  .pdcm_cmd(pdcm_cmd),
  .pdcm_q(pdcm_q),
  .offset_err_q(offset_err_q),
  .offset_init_done_q(offset_init_done_q)
);

// >>> testbench/ocm_pdcm_master.sv
// Periodic command source standing for the far-side bus master
module ocm_pdcm_master (
  input  wire logic               clk,
  input  wire ocm_pkg::ocm_pdcm_s pdcm_q,
  output logic                    pdcm_cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  import ocm_pkg::*;
  initial pdcm_cmd = 1'b0;

  // One-cycle command, then catch the word framed for transfer
  task automatic request(output ocm_pdcm_s w, output logic ok);
    ok = 1'b0;
    w = '0;
    @(posedge clk) pdcm_cmd <= 1'b1;
    @(posedge clk) pdcm_cmd <= 1'b0;
    // Look just after each edge, so the one-cycle valid is not missed
    repeat (3) begin
      #1;
      if (!ok && pdcm_q.valid === 1'b1) begin
        w = pdcm_q;
        ok = 1'b1;
      end
      @(posedge clk);
    end
  endtask
endmodule

// >>> testbench/offset_cancel_monitor_output_scaling_bench.sv
// Self-checking bench for the offset cancel and output scaling stage
module offset_cancel_monitor_output_scaling_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import ocm_pkg::*;
  typedef struct {
    logic signed [25:0] s;
    logic [15:0]        r16;
    logic [9:0]         w10;
    logic [13:0]        w14;
  } ocm_row_s;
  ocm_row_s rows [7] = '{
    '{26'sh0000000, 16'h8000, 10'h200, 14'h2000},
    '{26'sh0000400, 16'h8001, 10'h201, 14'h2001},
    '{26'sh3fffc00, 16'h7fff, 10'h1ff, 14'h1fff},
    '{26'sh007fc00, 16'h81ff, 10'h3ff, 14'h21ff},
    '{26'sh0080000, 16'h8200, 10'h3ff, 14'h2200},
    '{26'sh1ffffff, 16'hffff, 10'h3ff, 14'h3fff},
    '{26'sh2000000, 16'h0001, 10'h001, 14'h0001}};
  logic clk, reset_n, sample_valid, pdcm_cmd;
  logic signed [25:0] sample_in;
  ocm_pdcm_s pdcm_q;
  logic offset_err_q, offset_init_done_q;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int n_mismatch, checked, cyc;

  ocm_top #(.PHASE1_CYC(50), .PHASE2_CYC(50), .MON_START_CYC(300),
    .RATE_CYC(20)) dut (
    .clk(clk), .reset_n(reset_n), .sample_valid(sample_valid),
    .sample_in(sample_in), .pdcm_cmd(pdcm_cmd), .pdcm_q(pdcm_q),
    .offset_err_q(offset_err_q), .offset_init_done_q(offset_init_done_q),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  ocm_pdcm_master pm (.clk(clk), .pdcm_q(pdcm_q), .pdcm_cmd(pdcm_cmd));

  // Clock and hang guard
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus write: address and data offered together, held until taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    r = 2'b11;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 50) begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        n = 99;
      end
    end
  endtask

  // Bus read: address held until taken, data taken with rvalid
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    d = 32'hffffffff;
    r = 2'b11;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 50) begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        n = 99;
      end
    end
  endtask

  // Samples one every 20 cycles
  task automatic feed(input logic signed [25:0] v, input int n);
    repeat (n) begin
      @(posedge clk);
      sample_valid <= 1'b1;
      sample_in <= v;
      @(posedge clk);
      sample_valid <= 1'b0;
      repeat (18) @(posedge clk);
    end
  endtask

  task automatic res16(output logic [15:0] v);
    logic [31:0] h, l;
    logic [1:0] r;
    axi_rd(8'h0c, h, r);
    axi_rd(8'h10, l, r);
    v = {h[7:0], l[7:0]};
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] a, b;
    ocm_pdcm_s w;
    logic ok;
    {clk, reset_n, sample_valid, awvalid, wvalid, bready} = '0;
    {arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
    sample_in = '0;
    {n_mismatch, checked, cyc} = '0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    axi_rd(8'h00, d, r);
    chk(d, 32'h08);
    axi_rd(8'h14, d, r);
    chk(d, 32'h40);
    axi_rd(8'h0c, d, r);
    chk(d, 32'h80);
    axi_rd(8'h04, d, r);
    chk(d, 32'h0);
    axi_rd(8'h18, d, r);
    chk(r, 2'b10);
    feed(26'sh0400000, 6);
    axi_rd(8'h04, d, r);
    chk(d, 32'h1);
    axi_wr(8'h00, 32'h0, r);
    chk(r, 2'b00);
    for (int i = 0; i < 7; i++) begin
      feed(rows[i].s, 3);
      res16(a);
      chk(a, rows[i].r16);
      pm.request(w, ok);
      chk({ok, w.word14, w.word10}, {1'b1, rows[i].w14, rows[i].w10});
    end
    axi_wr(8'h14, 32'h2, r);
    axi_wr(8'h00, 32'h08, r);
    feed(26'sh0100000, 30);
    chk(offset_err_q, 1'b1);
    axi_rd(8'h04, d, r);
    chk(d[1:0], 2'b11);
    axi_rd(8'h08, d, r);
    chk(d[0], 1'b1);
    axi_wr(8'h00, 32'h18, r);
    feed(26'sh0, 2);
    res16(a);
    chk(a !== 16'h8000, 1'b1);
    feed(26'sh0, 4);
    res16(b);
    chk(b, a);
    axi_wr(8'h00, 32'h08, r);
    feed(26'sh0, 4);
    res16(b);
    chk(b !== a, 1'b1);
    // Rate limit on: one or two steps of one LSB between two samples
    axi_wr(8'h00, 32'h0c, r);
    feed(26'sh0, 1);
    res16(a);
    feed(26'sh0, 1);
    res16(b);
    chk(((b - a) inside {16'h1, 16'h2}), 1'b1);
    print_verdict();
  end
endmodule
